// ==== wwdf_top.sv ====
// Windowed watchdog: state machine, window timer, key check, flags and a
// simple register port. Assumes init_phase comes from logic on clk and the
// disable pin arrives asynchronously.
`default_nettype none

module wwdf_top #(
	parameter int RST_CYCLES = wwdf_pkg::RST_STATE_CYC, // timed reset length
	parameter int SVC_CYCLES = wwdf_pkg::FIRST_SVC_CYC  // first-service limit
) (
	input  wire logic        clk,            // 25 MHz system clock
	input  wire logic        rstn,           // Sync reset, active low
	input  wire logic [7:0]  reg_addr,       // Register byte address
	input  wire logic [31:0] reg_wdata,      // Write data
	input  wire logic        reg_wr,         // Write strobe
	input  wire logic        reg_rd,         // Read strobe
	output logic      [31:0] reg_rdata,      // Read data, cycle after strobe
	input  wire logic        disable_pin,    // Async disable pin level
	input  wire logic        init_phase,     // Device in init operating state
	output logic             arm_enable,     // Arming allowed
	output logic             wd_reset_out,   // Reset pulse to pin driver
	output logic             refresh_ok,     // One-cycle refresh accepted
	output logic             window_error,   // One-cycle window error
	output logic             run_equiv,      // Run or override state
	output logic             test_mode_flag, // In test state
	output logic             lockout_flag,   // Latched lockout
	output logic             wdog_reset_flag // Latched watchdog reset
);

	// Counter widths follow the lengths, so short bench counts fit too
	localparam int RW = $clog2(RST_CYCLES + 1);
	localparam int SW = $clog2(SVC_CYCLES + 1);
	localparam logic [10:0] FAST_LAST = 11'(wwdf_pkg::FAST_TICK_CYC - 1);
	localparam logic [10:0] SLOW_LAST = 11'(wwdf_pkg::SLOW_TICK_CYC - 1);
	localparam logic [7:0]  FAST_MAX  = 8'(wwdf_pkg::FAST_MAX_TICKS);
	localparam logic [7:0]  SLOW_MAX  = 8'(wwdf_pkg::SLOW_MAX_TICKS);
	localparam logic [RW-1:0] RST_LAST = RW'(RST_CYCLES - 1);
	localparam logic [SW-1:0] SVC_LAST = SW'(SVC_CYCLES - 1);

	wwdf_pkg::wwdf_state_t state_q;
	wwdf_pkg::wwdf_state_t state_d;

	logic        dis_meta_q;
	logic        dis_q;
	logic        slow_q;
	logic [7:0]  win_min_q;
	logic [7:0]  win_dlt_q;
	logic        tovr_q;
	logic [10:0] pre_q;
	logic [7:0]  timer_q;
	logic        key_a_q;
	logic        key_b_q;
	logic [RW-1:0] rst_cnt_q;
	logic [SW-1:0] svc_cnt_q;

	logic        wr_cfg;
	logic        wr_key;
	logic        wr_ctl;
	logic        cmd_test;
	logic        cmd_frst;
	logic        tick_c;
	logic [8:0]  win_end_c;
	logic        in_win_c;
	logic        late_c;
	logic        is_a_c;
	logic        is_b_c;
	logic        err_c;
	logic        ok_c;
	logic        restart_c;
	logic        clr_keys_c;
	logic        pair_c;
	logic [7:0]  win_max_c;
	logic        lock_now_c;
	logic        run_like_c;
	logic [31:0] rd_word_c;

	// Disable pin is asynchronous
	// Only the second stage is read; the first may be metastable
	always_ff @(posedge clk) begin
		if (!rstn) begin
			dis_meta_q <= 1'b0;
			dis_q      <= 1'b0;
		end else begin
			dis_meta_q <= disable_pin;
			dis_q      <= dis_meta_q;
		end
	end

	assign wr_cfg   = reg_wr && (reg_addr == wwdf_pkg::OFS_CONFIG);
	assign wr_key   = reg_wr && (reg_addr == wwdf_pkg::OFS_TIMER);
	assign wr_ctl   = reg_wr && (reg_addr == wwdf_pkg::OFS_CONTROL);
	assign cmd_test = wr_ctl && reg_wdata[wwdf_pkg::CTL_TEST_BIT];
	assign cmd_frst = wr_ctl && reg_wdata[wwdf_pkg::CTL_FRST_BIT];
	assign is_a_c   = wr_key && (reg_wdata[1:0] == wwdf_pkg::KEY_A);
	assign is_b_c   = wr_key && (reg_wdata[1:0] == wwdf_pkg::KEY_B);
	// Second distinct key completes a pair, in either order
	assign pair_c   = (is_a_c && key_b_q) || (is_b_c && key_a_q);

	// Configuration; frozen once the device leaves init
	always_ff @(posedge clk) begin
		if (!rstn) begin
			slow_q    <= 1'b0;
			win_min_q <= wwdf_pkg::RST_WIN_MIN;
			win_dlt_q <= wwdf_pkg::RST_WIN_DLT;
		end else if (wr_cfg && init_phase) begin
			slow_q    <= reg_wdata[wwdf_pkg::CFG_SLOW_BIT];
			win_min_q <= reg_wdata[wwdf_pkg::CFG_MIN_LSB +: 8];
			win_dlt_q <= reg_wdata[wwdf_pkg::CFG_DLT_LSB +: 8];
		end
	end

	// Override bit is sticky until a state-machine reset
	always_ff @(posedge clk) begin
		if (!rstn || cmd_frst) begin
			tovr_q <= 1'b0;
		end else if (wr_ctl && reg_wdata[wwdf_pkg::CTL_TOVR_BIT]) begin
			tovr_q <= 1'b1;
		end
	end

	// Tick prescaler; slow mode shares the same 8-bit window fields
	assign tick_c = pre_q == (slow_q ? SLOW_LAST : FAST_LAST);

	always_ff @(posedge clk) begin
		if (!rstn || restart_c || dis_q) begin
			pre_q <= 11'h000;
		end else if (tick_c) begin
			pre_q <= 11'h000;
		end else begin
			pre_q <= pre_q + 11'h001;
		end
	end

	assign win_end_c = {1'b0, win_min_q} + {1'b0, win_dlt_q};
	assign in_win_c  = (timer_q >= win_min_q) && ({1'b0, timer_q} <= win_end_c);
	// Range end counts as late too, so a window past the range cannot hang
	assign win_max_c = slow_q ? SLOW_MAX : FAST_MAX;
	assign late_c    = ({1'b0, timer_q} > win_end_c) ||
		(timer_q == win_max_c);

	// Error, refresh and state decisions
	always_comb begin
		state_d    = state_q;
		err_c      = 1'b0;
		ok_c       = 1'b0;
		restart_c  = 1'b0;
		clr_keys_c = 1'b0;
		case (state_q)
			wwdf_pkg::ST_INITIAL: begin
				restart_c = 1'b1;
				if (dis_q) begin
					clr_keys_c = 1'b1;
					if (cmd_test) begin
						state_d = wwdf_pkg::ST_OVERRIDE;
					end
				end else if (pair_c) begin
					clr_keys_c = 1'b1;
					state_d    = wwdf_pkg::ST_RUN; // service begins
				end else if (!tovr_q && svc_cnt_q == SVC_LAST) begin
					err_c   = 1'b1;
					state_d = wwdf_pkg::ST_TRESET;
				end
			end
			wwdf_pkg::ST_RUN, wwdf_pkg::ST_TEST: begin
				if (dis_q) begin
					restart_c  = 1'b1;
					clr_keys_c = 1'b1;
				end else if (((is_a_c || is_b_c) && !in_win_c) || late_c) begin
					err_c   = 1'b1;
					state_d = wwdf_pkg::ST_TRESET;
				end else if (pair_c) begin
					ok_c       = 1'b1;
					restart_c  = 1'b1;
					clr_keys_c = 1'b1;
				end else if (cmd_test && state_q == wwdf_pkg::ST_RUN) begin
					state_d = wwdf_pkg::ST_TEST;
				end
			end
			wwdf_pkg::ST_TRESET: begin
				restart_c  = 1'b1;
				clr_keys_c = 1'b1;
				if (rst_cnt_q == RST_LAST) begin
					state_d = wwdf_pkg::ST_INITIAL;
				end
			end
			wwdf_pkg::ST_OVERRIDE: begin
				restart_c  = 1'b1;
				clr_keys_c = 1'b1;
			end
			default: begin
				state_d = wwdf_pkg::ST_INITIAL;
			end
		endcase
		if (cmd_frst) begin
			state_d    = wwdf_pkg::ST_INITIAL;
			err_c      = 1'b0;
			ok_c       = 1'b0;
			restart_c  = 1'b1;
			clr_keys_c = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_q <= wwdf_pkg::ST_INITIAL;
		end else begin
			state_q <= state_d;
		end
	end

	// Window timer in ticks, saturating at the range end
	always_ff @(posedge clk) begin
		if (!rstn || restart_c) begin
			timer_q <= 8'h00;
		end else if (tick_c && timer_q != win_max_c) begin
			timer_q <= timer_q + 8'h01;
		end
	end

	// Half-sequence memory; a wrong or repeated key changes nothing
	always_ff @(posedge clk) begin
		if (!rstn || clr_keys_c || err_c) begin
			key_a_q <= 1'b0;
			key_b_q <= 1'b0;
		end else begin
			if (is_a_c) begin
				key_a_q <= 1'b1;
			end
			if (is_b_c) begin
				key_b_q <= 1'b1;
			end
		end
	end

	// Timed reset length and first-service limit
	always_ff @(posedge clk) begin
		if (!rstn || state_q != wwdf_pkg::ST_TRESET) begin
			rst_cnt_q <= '0;
		end else if (rst_cnt_q != RST_LAST) begin
			rst_cnt_q <= rst_cnt_q + RW'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn || cmd_frst || state_q != wwdf_pkg::ST_INITIAL ||
			dis_q || tovr_q) begin
			svc_cnt_q <= '0;
		end else if (svc_cnt_q != SVC_LAST) begin
			svc_cnt_q <= svc_cnt_q + SW'(1);
		end
	end

	// Errors outside test lock arming out until a state-machine reset
	assign lock_now_c = err_c && state_q != wwdf_pkg::ST_TEST;
	assign run_like_c = state_d == wwdf_pkg::ST_RUN ||
		state_d == wwdf_pkg::ST_OVERRIDE;

	// Reset flag survives the timed reset for software to read
	always_ff @(posedge clk) begin
		if (!rstn || cmd_frst) begin
			wdog_reset_flag <= 1'b0;
		end else if (err_c) begin
			wdog_reset_flag <= 1'b1;
		end
	end

	// Lockout has no software clear of its own
	always_ff @(posedge clk) begin
		if (!rstn || cmd_frst) begin
			lockout_flag <= 1'b0;
		end else if (lock_now_c) begin
			lockout_flag <= 1'b1;
		end
	end

	// Levels follow the next state, so they align with state_q
	always_ff @(posedge clk) begin
		if (!rstn) begin
			arm_enable     <= 1'b0;
			run_equiv      <= 1'b0;
			test_mode_flag <= 1'b0;
		end else begin
			// Lockout set by this error must already block arming
			arm_enable     <= run_like_c && !lockout_flag &&
				!lock_now_c;
			run_equiv      <= run_like_c;
			test_mode_flag <= state_d == wwdf_pkg::ST_TEST;
		end
	end

	// Reset request lasts exactly as long as the timed reset state
	always_ff @(posedge clk) begin
		if (!rstn) begin
			wd_reset_out <= 1'b0;
		end else begin
			wd_reset_out <= state_d == wwdf_pkg::ST_TRESET;
		end
	end

	// One-cycle event pulses
	always_ff @(posedge clk) begin
		if (!rstn) begin
			refresh_ok   <= 1'b0;
			window_error <= 1'b0;
		end else begin
			refresh_ok   <= ok_c;
			window_error <= err_c;
		end
	end

	// Read mux; the register stage keeps the address path short
	always_comb begin
		rd_word_c = 32'h00000000;
		case (reg_addr)
			wwdf_pkg::OFS_CONFIG: begin
				rd_word_c = {8'h00, win_dlt_q, win_min_q, 7'h00, slow_q};
			end
			wwdf_pkg::OFS_TIMER: begin
				rd_word_c = {24'h000000, timer_q};
			end
			wwdf_pkg::OFS_CONTROL: begin
				rd_word_c = {30'h00000000, tovr_q, 1'b0};
			end
			wwdf_pkg::OFS_STATUS: begin
				rd_word_c = {23'h000000, state_q, dis_q,
					test_mode_flag, lockout_flag, wdog_reset_flag};
			end
			default: begin
				rd_word_c = 32'h00000000;
			end
		endcase
	end

	// Read data valid only in the cycle after the strobe
	always_ff @(posedge clk) begin
		if (!rstn || !reg_rd) begin
			reg_rdata <= 32'h00000000;
		end else begin
			reg_rdata <= rd_word_c;
		end
	end

endmodule : wwdf_top

`default_nettype wire

// ==== wwdf_pkg.sv ====
// Constants for the windowed watchdog: register map, fields, keys, timing.
// Assumes a 25 MHz system clock; all times are derived from CLK_NS.
`default_nettype none

package wwdf_pkg;

	// Register offsets (byte addresses, one 32-bit word each)
	localparam logic [7:0] OFS_CONFIG  = 8'h00;
	localparam logic [7:0] OFS_TIMER   = 8'h04;
	localparam logic [7:0] OFS_CONTROL = 8'h08;
	localparam logic [7:0] OFS_STATUS  = 8'h0C;

	// Config fields
	localparam int CFG_SLOW_BIT = 0;
	localparam int CFG_MIN_LSB  = 8;
	localparam int CFG_DLT_LSB  = 16;

	// Control fields (write-one actions)
	localparam int CTL_TEST_BIT = 0;
	localparam int CTL_TOVR_BIT = 1;
	localparam int CTL_FRST_BIT = 2;

	// Status fields
	localparam int ST_WDR_BIT  = 0;
	localparam int ST_LOCK_BIT = 1;
	localparam int ST_TM_BIT   = 2;
	localparam int ST_DIS_BIT  = 3;
	localparam int ST_FSM_LSB  = 4;

	// Key codes written to the key field
	localparam logic [1:0] KEY_A = 2'h1;
	localparam logic [1:0] KEY_B = 2'h2;

	// Reset values
	localparam logic [7:0] RST_WIN_MIN = 8'h10;
	localparam logic [7:0] RST_WIN_DLT = 8'h20;

	// Timing, each figure in its own unit
	localparam int CLK_NS        = 40;
	localparam int FAST_RES_NS   = 8000;
	localparam int SLOW_RES_NS   = 64000;
	localparam int FAST_RANGE_US = 2000;
	localparam int SLOW_RANGE_US = 16300;
	localparam int RST_STATE_US  = 1000;
	localparam int FIRST_SVC_MS  = 500;

	localparam int FAST_TICK_CYC = FAST_RES_NS / CLK_NS;
	localparam int SLOW_TICK_CYC = SLOW_RES_NS / CLK_NS;
	localparam int FAST_MAX_TICKS = FAST_RANGE_US * 1000 / FAST_RES_NS;
	localparam int SLOW_MAX_TICKS = SLOW_RANGE_US * 1000 / SLOW_RES_NS;
	localparam int RST_STATE_CYC = RST_STATE_US * 1000 / CLK_NS;
	localparam int FIRST_SVC_CYC = FIRST_SVC_MS * 1000 * (1000 / CLK_NS);

	// One-hot watchdog states
	typedef enum logic [4:0] {
		ST_INITIAL  = 5'h01,
		ST_RUN      = 5'h02,
		ST_TEST     = 5'h04,
		ST_TRESET   = 5'h08,
		ST_OVERRIDE = 5'h10
	} wwdf_state_t;

endpackage : wwdf_pkg

`default_nettype wire

// ==== wwdf_top_sva.sv ====
// Concurrent checks on the watchdog ports, bound into wwdf_top.
// Assumes RST_CYCLES is shortened so the reset-state count stays small.
`default_nettype none

module wwdf_chk #(
	parameter int RST_CYCLES = 20 // Timed reset length
) (
	input wire logic        clk,            // Clock
	input wire logic        rstn,           // Sync reset
	input wire logic [7:0]  reg_addr,       // Address
	input wire logic [31:0] reg_wdata,      // Write data
	input wire logic        reg_wr,         // Write strobe
	input wire logic        reg_rd,         // Read strobe
	input wire logic [31:0] reg_rdata,      // Read data
	input wire logic        disable_pin,    // Disable pin
	input wire logic        init_phase,     // Init phase
	input wire logic        arm_enable,     // Arming allowed
	input wire logic        wd_reset_out,   // Reset pulse
	input wire logic        refresh_ok,     // Refresh pulse
	input wire logic        window_error,   // Error pulse
	input wire logic        run_equiv,      // Run or override
	input wire logic        test_mode_flag, // Test state
	input wire logic        lockout_flag,   // Lockout
	input wire logic        wdog_reset_flag // Reset flag
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	logic [15:0] hi_q;
	wire         frst = reg_wr && reg_addr == wwdf_pkg::OFS_CONTROL
		&& reg_wdata[wwdf_pkg::CTL_FRST_BIT];

	// Counts cycles spent in the timed reset state
	always_ff @(posedge clk) begin
		hi_q <= (rstn && wd_reset_out) ? hi_q + 16'h1 : 16'h0;
	end

	sequence s_leave;
		$fell(wd_reset_out);
	endsequence

	rdata_idle_a: assert property (
		!reg_rd |=> reg_rdata == 32'h0) else $error("rdata not idle");
	pulse_excl_a: assert property (
		!(refresh_ok && window_error)) else $error("ok with error");
	err_enter_a: assert property (
		window_error |-> wd_reset_out && wdog_reset_flag)
		else $error("error without reset state");
	rst_len_a: assert property (
		wd_reset_out |-> hi_q < RST_CYCLES) else $error("reset too long");
	rst_exit_a: assert property (
		s_leave |-> hi_q == RST_CYCLES && !run_equiv && !arm_enable)
		else $error("bad reset exit");
	arm_block_a: assert property (
		lockout_flag || test_mode_flag |-> !arm_enable)
		else $error("arming not blocked");
	test_norun_a: assert property (
		test_mode_flag |-> !run_equiv) else $error("test seen as run");
	lock_hold_a: assert property (
		lockout_flag && !frst |=> lockout_flag) else $error("lock lost");
	flag_hold_a: assert property (
		wdog_reset_flag && !frst |=> wdog_reset_flag)
		else $error("reset flag lost");
	dis_quiet_a: assert property (
		disable_pin [*4] |-> !window_error) else $error("error disabled");
	fsm_clear_a: assert property (
		frst |=> !lockout_flag && !wdog_reset_flag && !wd_reset_out)
		else $error("fsm reset left flags");
endmodule : wwdf_chk

`default_nettype wire

// ==== wwdf_host_model.sv ====
// Host model: register-bus master sending config, key and control writes.
// Assumes the slave never stalls and read data stand one cycle later.
`default_nettype none

module wwdf_host (
	input  wire logic        clk,       // System clock
	output logic      [7:0]  reg_addr,  // Address
	output logic      [31:0] reg_wdata, // Write data
	output logic             reg_wr,    // Write strobe
	output logic             reg_rd,    // Read strobe
	input  wire logic [31:0] reg_rdata  // Read data
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	// Idle bus shows flipped values so stale data never looks valid
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		// Data stand until the next edge and are taken there
		@(posedge clk);
		d = reg_rdata;
	endtask : rd

	task automatic key(input logic [1:0] k);
		wr(wwdf_pkg::OFS_TIMER, {30'h0, k});
	endtask : key

	// Writes key A then key B back to back; when to serve is left to the caller
	task automatic refresh();
		key(wwdf_pkg::KEY_A);
		key(wwdf_pkg::KEY_B);
	endtask : refresh
endmodule : wwdf_host

`default_nettype wire

// ==== wwdf_top_test.sv ====
// Bench top: host model drives the register port, outputs are compared.
// Assumes shortened reset and first-service counts to keep the run short.
`default_nettype none

module wwdf_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int RC = 20;
	localparam int SC = 200;
	localparam int TK = wwdf_pkg::FAST_TICK_CYC;

	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        disable_pin = 1'b0;
	logic        init_phase = 1'b1;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic        reg_wr, reg_rd, arm_enable, wd_reset_out, refresh_ok;
	logic        window_error, run_equiv, test_mode_flag, lockout_flag;
	logic        wdog_reset_flag;
	int          n_mismatch = 0;
	int          num_checks = 0;
	int          n_err = 0;
	int          n_ok = 0;
	int          ok0;

	always #20 clk = ~clk;

	always @(posedge clk) begin
		if (window_error === 1'b1) n_err <= n_err + 1;
		if (refresh_ok === 1'b1) n_ok <= n_ok + 1;
	end

	wwdf_host u_host (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata);
	wwdf_top #(.RST_CYCLES(RC), .SVC_CYCLES(SC)) DUT (.clk, .rstn,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .disable_pin,
		.init_phase, .arm_enable, .wd_reset_out, .refresh_ok, .window_error,
		.run_equiv, .test_mode_flag, .lockout_flag, .wdog_reset_flag);

	function automatic logic [31:0] st(input logic [4:0] s,
		input logic [3:0] f);
		return {23'h0, s, f};
	endfunction : st

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		u_host.rd(a, d);
		chk(d, exp);
	endtask : rchk

	task automatic print_verdict();
		$display("Counts: %0d mismatches, %0d checks", n_mismatch, num_checks);
		if (n_mismatch == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : print_verdict

	// A missing error pulse ends the run rather than hanging it
	task automatic wait_err(input int n, input int lim);
		for (int i = 0; i < lim && n_err < n; i++) @(posedge clk);
		if (n_err < n) begin
			n_mismatch++;
			print_verdict();
		end
	endtask : wait_err

	initial begin
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		rchk(wwdf_pkg::OFS_STATUS, st(wwdf_pkg::ST_INITIAL, 4'h0));
		chk({31'h0, arm_enable}, 32'h0);
		rchk(wwdf_pkg::OFS_CONFIG, {8'h00, wwdf_pkg::RST_WIN_DLT,
			wwdf_pkg::RST_WIN_MIN, 8'h00});
		u_host.wr(wwdf_pkg::OFS_CONFIG, 32'h00030200);
		init_phase <= 1'b0;
		u_host.wr(wwdf_pkg::OFS_CONFIG, 32'h00FFFF01);
		rchk(wwdf_pkg::OFS_CONFIG, 32'h00030200);
		rchk(8'h20, 32'h0);
		u_host.refresh();
		rchk(wwdf_pkg::OFS_STATUS, st(wwdf_pkg::ST_RUN, 4'h0));
		chk({31'h0, arm_enable}, 32'h1);
		u_host.key(2'h0);
		u_host.key(2'h3);
		chk(n_err, 0);
		repeat (3 * TK) @(posedge clk);
		rchk(wwdf_pkg::OFS_TIMER, 32'h3);
		ok0 = n_ok;
		u_host.refresh();
		repeat (2) @(posedge clk);
		chk(n_ok - ok0, 1);
		rchk(wwdf_pkg::OFS_TIMER, 32'h0);
		u_host.key(wwdf_pkg::KEY_A);
		wait_err(1, 10);
		rchk(wwdf_pkg::OFS_STATUS, st(wwdf_pkg::ST_TRESET, 4'h3));
		repeat (RC) @(posedge clk);
		rchk(wwdf_pkg::OFS_STATUS, st(wwdf_pkg::ST_INITIAL, 4'h3));
		u_host.wr(wwdf_pkg::OFS_CONTROL, 32'h4);
		rchk(wwdf_pkg::OFS_STATUS, st(wwdf_pkg::ST_INITIAL, 4'h0));
		u_host.refresh();
		u_host.wr(wwdf_pkg::OFS_CONTROL, 32'h1);
		rchk(wwdf_pkg::OFS_STATUS, st(wwdf_pkg::ST_TEST, 4'h4));
		chk({31'h0, arm_enable}, 32'h0);
		wait_err(2, 8 * TK);
		repeat (RC + 2) @(posedge clk);
		rchk(wwdf_pkg::OFS_STATUS, st(wwdf_pkg::ST_INITIAL, 4'h1));
		wait_err(3, SC + 50);
		repeat (RC + 2) @(posedge clk);
		u_host.wr(wwdf_pkg::OFS_CONTROL, 32'h4);
		u_host.wr(wwdf_pkg::OFS_CONTROL, 32'h1);
		rchk(wwdf_pkg::OFS_STATUS, st(wwdf_pkg::ST_INITIAL, 4'h0));
		u_host.wr(wwdf_pkg::OFS_CONTROL, 32'h2);
		repeat (SC + 50) @(posedge clk);
		chk(n_err, 3);
		rchk(wwdf_pkg::OFS_CONTROL, 32'h2);
		disable_pin <= 1'b1;
		repeat (3) @(posedge clk);
		u_host.wr(wwdf_pkg::OFS_CONTROL, 32'h1);
		rchk(wwdf_pkg::OFS_STATUS, st(wwdf_pkg::ST_OVERRIDE, 4'h8));
		chk({30'h0, run_equiv, arm_enable}, 32'h3);
		rchk(wwdf_pkg::OFS_TIMER, 32'h0);
		disable_pin <= 1'b0;
		repeat (3) @(posedge clk);
		u_host.wr(wwdf_pkg::OFS_CONTROL, 32'h4);
		init_phase <= 1'b1;
		u_host.wr(wwdf_pkg::OFS_CONFIG, 32'h00010101);
		init_phase <= 1'b0;
		u_host.refresh();
		repeat (wwdf_pkg::SLOW_TICK_CYC) @(posedge clk);
		rchk(wwdf_pkg::OFS_TIMER, 32'h1);
		chk(n_err, 3);
		wait_err(4, 4 * wwdf_pkg::SLOW_TICK_CYC);
		rchk(wwdf_pkg::OFS_STATUS, st(wwdf_pkg::ST_TRESET, 4'h3));
		print_verdict();
	end
endmodule : wwdf_top_test

bind wwdf_top wwdf_chk #(.RST_CYCLES(RST_CYCLES)) u_chk (.clk, .rstn,
	.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .disable_pin,
	.init_phase, .arm_enable, .wd_reset_out, .refresh_ok, .window_error,
	.run_equiv, .test_mode_flag, .lockout_flag, .wdog_reset_flag);

`default_nettype wire
